// ### logic/mode_ctrl_pkg.sv
// Constants shared by the operating mode and wakeup controller
package mode_ctrl_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_WAKE_EN = 8'hC0;
    localparam logic [7:0] ADDR_MODE = 8'hC4;
    localparam logic [7:0] ADDR_STATUS = 8'hC8;

    // ****************************************
    // Mode control register fields
    // ****************************************
    localparam int BIT_HIGH_OSC_STOP = 1;
    localparam int BIT_SLOW_CLOCK_SELECT = 2;
    localparam int BIT_CPU_MODE_LO = 3;
    localparam int BIT_TIMER0_ENABLE = 5;

    // ****************************************
    // Status register fields
    // ****************************************
    localparam int BIT_ST_STATE_LO = 0;
    localparam int BIT_ST_HOSC_RUN = 2;
    localparam int BIT_ST_LRC_RUN = 3;
    localparam int BIT_ST_CPU_RUN = 4;
    localparam int BIT_ST_TIMER0_RUN = 5;

    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int P0_PINS = 8;
    localparam int P1_PINS = 6;
    localparam logic [5:0] WAKE_EN_RESET = 6'h00;
    localparam logic [1:0] CPU_MODE_RESET = 2'h0;
    localparam logic SLOW_RESET = 1'b0;
    localparam logic STOP_RESET = 1'b0;
    localparam logic TIMER0_EN_RESET = 1'b0;

    // ****************************************
    // Timing counts
    // ****************************************
    localparam int SETTLE_HOSC_CLOCKS = 2048;
    localparam logic [11:0] SETTLE_LAST = 12'(SETTLE_HOSC_CLOCKS - 1);
    localparam int SLOW_DIVIDE = 4;
    localparam logic [1:0] SLOW_DIV_LAST = 2'(SLOW_DIVIDE - 1);

    // ****************************************
    // Mode field encodings and controller states
    // ****************************************
    typedef enum logic [1:0] {
        CPU_NORMAL = 2'h0,
        CPU_SLEEP = 2'h1,
        CPU_GREEN = 2'h2,
        CPU_RESERVED = 2'h3
    } cpu_mode_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_SLEEP = 2'h1,
        ST_SETTLE = 2'h3,
        ST_GREEN = 2'h2
    } state_t;

endpackage : mode_ctrl_pkg

// ### logic/operating_mode_and_wakeup_control.sv
// Operating mode controller: normal, slow, sleep and green with wakeup
//
// How it works
// - Low RC clocks the watchdog and is system clock when slow select set.
// - In slow mode one instruction cycle per four low RC clocks.
// - Low RC stops only in sleep, or green with 32K option, watchdog off.
// - No separate low RC off control; it follows mode bits and options.
// - Instructions run in normal and slow, halt in green and sleep.
// - Timer 0 runs when enabled in normal, slow, green; never in sleep.
// - Only pin wake or reset ends sleep; device resumes in normal mode.
// - Sleep wakes on port 0 or port 1 level change, not timer overflow.
// - Green wake returns to previous mode; pins or timer 0 overflow wake.
// - Timer 0 overflow wakes green only while timer 0 is enabled.
// - Wake from sleep waits 2048 high oscillator clocks before running.
// - Wake from green resumes at once with no settling wait.
// - Port 0 pins always wake; port 1 pins only with own enable bit.
// - Port 1 wake enable: six write-only bits 5..0, reset to zero.
// - Mode field: 00 normal, 01 sleep, 10 green, 11 reserved; resets 00.
// - Slow select: 0 high clock, 1 low RC clock; resets to 0.
// - Oscillator stop: 0 high oscillator runs, 1 stops it; resets to 0.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
module operating_mode_and_wakeup_control (
    // Clock, reset and freeze
    input wire logic clock,
    input wire logic rstn,
    input wire logic enable,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Code options
    input wire logic opt_high_32k,
    input wire logic watchdog_disable,
    // Oscillator ticks, one cycle each
    input wire logic external_high_clock_tick,
    input wire logic internal_low_rc_tick,
    // Wake sources
    input wire logic [mode_ctrl_pkg::P0_PINS-1:0] port0_in,
    input wire logic [mode_ctrl_pkg::P1_PINS-1:0] port1_in,
    input wire logic timer_zero_overflow,
    // Oscillator and core controls
    output logic high_osc_run,
    output logic low_rc_run,
    output logic sys_clock_low,
    output logic watchdog_clock_on,
    output logic cpu_run,
    output logic cpu_cycle,
    output logic timer_zero_run
);

    // ****************************************
    // State
    // ****************************************
    mode_ctrl_pkg::state_t state_q;
    mode_ctrl_pkg::state_t state_d;
    logic [1:0] cpu_mode_field_q;
    logic slow_clock_select_q;
    logic high_osc_stop_q;
    logic timer0_enable_q;
    logic [mode_ctrl_pkg::P1_PINS-1:0] port1_pin_wake_enables_q;
    logic [11:0] settle_q;
    logic [1:0] div_q;
    logic pin_wake;
    logic green_wake;
    logic settle_done;
    logic wake_any;
    logic sleep_wake;
    logic [7:0] rdata_q;

    // Address match helper, used by every register decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    // ****************************************
    // Wake detection
    // ****************************************
    pin_wake_detect u_wake (
        .clock(clock),
        .rstn(rstn),
        .enable(enable),
        .hold(state_q == mode_ctrl_pkg::ST_SLEEP
            || state_q == mode_ctrl_pkg::ST_GREEN),
        .port0_in(port0_in),
        .port1_in(port1_in),
        .port1_pin_wake_enables(port1_pin_wake_enables_q),
        .wake(pin_wake)
    );

    // Timer overflow only counts in green and only while the timer runs
    assign green_wake = pin_wake
        || (timer0_enable_q && timer_zero_overflow);
    assign settle_done = external_high_clock_tick
        && (settle_q == mode_ctrl_pkg::SETTLE_LAST);
    // Settling over: the one edge on which sleep hands back to normal
    assign sleep_wake = (state_q == mode_ctrl_pkg::ST_SETTLE) && settle_done;
    assign wake_any = sleep_wake
        || (state_q == mode_ctrl_pkg::ST_GREEN && green_wake);

    // ****************************************
    // Mode state machine
    // ****************************************
    // Next state from the mode field and wake events
    always_comb begin
        state_d = state_q;
        case (state_q)
            mode_ctrl_pkg::ST_RUN: begin
                // Reserved code 11 leaves the core running
                if (cpu_mode_field_q == mode_ctrl_pkg::CPU_SLEEP) begin
                    state_d = mode_ctrl_pkg::ST_SLEEP;
                end else if (cpu_mode_field_q
                    == mode_ctrl_pkg::CPU_GREEN) begin
                    state_d = mode_ctrl_pkg::ST_GREEN;
                end
            end
            mode_ctrl_pkg::ST_SLEEP: begin
                // Timer overflow is deliberately not looked at here
                if (pin_wake) begin
                    state_d = mode_ctrl_pkg::ST_SETTLE;
                end
            end
            mode_ctrl_pkg::ST_SETTLE: begin
                if (settle_done) begin
                    state_d = mode_ctrl_pkg::ST_RUN;
                end
            end
            mode_ctrl_pkg::ST_GREEN: begin
                if (green_wake) begin
                    state_d = mode_ctrl_pkg::ST_RUN;
                end
            end
            default: begin
                state_d = mode_ctrl_pkg::ST_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= mode_ctrl_pkg::ST_RUN;
        end else if (enable) begin
            state_q <= state_d;
        end
    end

    // Settling counter counts high oscillator ticks only while settling
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            settle_q <= '0;
        end else if (enable) begin
            if (state_q != mode_ctrl_pkg::ST_SETTLE) begin
                settle_q <= '0;
            end else if (external_high_clock_tick) begin
                settle_q <= settle_q + 12'h001;
            end
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    // Mode field: software writes it, a wake clears it; the wake wins,
    // since no code runs in a halted mode to race with it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cpu_mode_field_q <= mode_ctrl_pkg::CPU_MODE_RESET;
        end else if (enable) begin
            if (wake_any) begin
                cpu_mode_field_q <= mode_ctrl_pkg::CPU_NORMAL;
            end else if (wr && hit(addr, mode_ctrl_pkg::ADDR_MODE)) begin
                cpu_mode_field_q <=
                    wdata[mode_ctrl_pkg::BIT_CPU_MODE_LO +: 2];
            end
        end
    end

    // Clock select and timer 0 enable bits; a sleep wake forces normal mode on the high clock
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            slow_clock_select_q <= mode_ctrl_pkg::SLOW_RESET;
            high_osc_stop_q <= mode_ctrl_pkg::STOP_RESET;
            timer0_enable_q <= mode_ctrl_pkg::TIMER0_EN_RESET;
        end else if (enable) begin
            if (sleep_wake) begin
                slow_clock_select_q <= 1'b0;
                high_osc_stop_q <= 1'b0;
            end else if (wr && hit(addr, mode_ctrl_pkg::ADDR_MODE)) begin
                // Green wake leaves these alone, so the old mode returns
                slow_clock_select_q <=
                    wdata[mode_ctrl_pkg::BIT_SLOW_CLOCK_SELECT];
                high_osc_stop_q <=
                    wdata[mode_ctrl_pkg::BIT_HIGH_OSC_STOP];
                timer0_enable_q <= wdata[mode_ctrl_pkg::BIT_TIMER0_ENABLE];
            end
        end
    end

    // Port 1 wake enables, write only
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            port1_pin_wake_enables_q <= mode_ctrl_pkg::WAKE_EN_RESET;
        end else if (enable && wr
            && hit(addr, mode_ctrl_pkg::ADDR_WAKE_EN)) begin
            port1_pin_wake_enables_q <= wdata[5:0];
        end
    end

    // ****************************************
    // Instruction cycle strobe
    // ****************************************
    // Slow mode divides low RC ticks by four; normal passes high ticks
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_q <= '0;
            cpu_cycle <= 1'b0;
        end else if (enable) begin
            if (state_d != mode_ctrl_pkg::ST_RUN
                || state_q != mode_ctrl_pkg::ST_RUN) begin
                div_q <= '0;
                cpu_cycle <= 1'b0;
            end else if (slow_clock_select_q) begin
                if (internal_low_rc_tick) begin
                    div_q <= div_q + 2'h1;
                end
                cpu_cycle <= internal_low_rc_tick
                    && (div_q == mode_ctrl_pkg::SLOW_DIV_LAST);
            end else begin
                div_q <= '0;
                cpu_cycle <= external_high_clock_tick;
            end
        end
    end

    // ****************************************
    // Oscillator and core enables
    // ****************************************
    // Registered from the next state, so each output moves with the state
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            high_osc_run <= 1'b1;
            low_rc_run <= 1'b1;
            sys_clock_low <= 1'b0;
            watchdog_clock_on <= 1'b1;
            cpu_run <= 1'b1;
            timer_zero_run <= 1'b0;
        end else if (enable) begin
            // Settling needs the high oscillator back on
            high_osc_run <= (state_d == mode_ctrl_pkg::ST_SETTLE)
                || (state_d != mode_ctrl_pkg::ST_SLEEP
                && (sleep_wake || !high_osc_stop_q));
            // Low RC has no control of its own, only the mode and code options decide
            low_rc_run <= !(state_d == mode_ctrl_pkg::ST_SLEEP
                || state_d == mode_ctrl_pkg::ST_SETTLE
                || (state_d == mode_ctrl_pkg::ST_GREEN
                && opt_high_32k && watchdog_disable));
            watchdog_clock_on <= !(state_d == mode_ctrl_pkg::ST_SLEEP
                || state_d == mode_ctrl_pkg::ST_SETTLE
                || (state_d == mode_ctrl_pkg::ST_GREEN
                && opt_high_32k && watchdog_disable));
            // Sleep wake drops slow select this edge, so follow it now
            sys_clock_low <= slow_clock_select_q
                && !sleep_wake;
            cpu_run <= (state_d == mode_ctrl_pkg::ST_RUN);
            timer_zero_run <= timer0_enable_q
                && (state_d == mode_ctrl_pkg::ST_RUN
                || state_d == mode_ctrl_pkg::ST_GREEN);
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else if (enable) begin
            rdata_q <= 8'h00;
            if (rd && hit(addr, mode_ctrl_pkg::ADDR_MODE)) begin
                rdata_q[mode_ctrl_pkg::BIT_CPU_MODE_LO +: 2] <=
                    cpu_mode_field_q;
                rdata_q[mode_ctrl_pkg::BIT_SLOW_CLOCK_SELECT] <=
                    slow_clock_select_q;
                rdata_q[mode_ctrl_pkg::BIT_HIGH_OSC_STOP] <= high_osc_stop_q;
                rdata_q[mode_ctrl_pkg::BIT_TIMER0_ENABLE] <= timer0_enable_q;
            end else if (rd && hit(addr, mode_ctrl_pkg::ADDR_STATUS)) begin
                rdata_q[mode_ctrl_pkg::BIT_ST_STATE_LO +: 2] <= state_q;
                rdata_q[mode_ctrl_pkg::BIT_ST_HOSC_RUN] <= high_osc_run;
                rdata_q[mode_ctrl_pkg::BIT_ST_LRC_RUN] <= low_rc_run;
                rdata_q[mode_ctrl_pkg::BIT_ST_CPU_RUN] <= cpu_run;
                rdata_q[mode_ctrl_pkg::BIT_ST_TIMER0_RUN] <= timer_zero_run;
            end
            // Wake enable register is write only and reads as zero
        end
    end

    assign rdata = rdata_q;

endmodule : operating_mode_and_wakeup_control

// ### logic/pin_wake_detect.sv
// Level-change wake detector over both wake-capable ports
`timescale 1ns/100ps
module pin_wake_detect (
    // Clock, reset and freeze
    input wire logic clock,
    input wire logic rstn,
    input wire logic enable,
    // Snapshot control: reference levels follow pins while hold is low
    input wire logic hold,
    // Pins and per-pin enables
    input wire logic [mode_ctrl_pkg::P0_PINS-1:0] port0_in,
    input wire logic [mode_ctrl_pkg::P1_PINS-1:0] port1_in,
    input wire logic [mode_ctrl_pkg::P1_PINS-1:0] port1_pin_wake_enables,
    // Any enabled pin differs from its reference level
    output logic wake
);

    // ****************************************
    // Reference levels
    // ****************************************
    logic [mode_ctrl_pkg::P0_PINS-1:0] ref0_q;
    logic [mode_ctrl_pkg::P1_PINS-1:0] ref1_q;
    logic [mode_ctrl_pkg::P0_PINS-1:0] hit0;
    logic [mode_ctrl_pkg::P1_PINS-1:0] hit1;

    // Track pins while running, freeze on entry to a halted mode
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ref0_q <= '0;
            ref1_q <= '0;
        end else if (enable && !hold) begin
            ref0_q <= port0_in;
            ref1_q <= port1_in;
        end
    end

    // ****************************************
    // Per-pin compare
    // ****************************************
    // A level compare, not an edge: a change that happened while no
    // oscillator ran is still seen once it is sampled
    genvar i;
    generate
        for (i = 0; i < mode_ctrl_pkg::P0_PINS; i++) begin : g_p0
            assign hit0[i] = port0_in[i] ^ ref0_q[i];
        end
        for (i = 0; i < mode_ctrl_pkg::P1_PINS; i++) begin : g_p1
            assign hit1[i] = port1_pin_wake_enables[i]
                & (port1_in[i] ^ ref1_q[i]);
        end
    endgenerate

    // Combined wake request
    assign wake = hold && ((|hit0) || (|hit1));

endmodule : pin_wake_detect

// ### tb/mode_ctrl_props.sv
// Port checker for the operating mode and wakeup controller
`timescale 1ns/100ps
module mode_ctrl_props (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port and options
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic opt_high_32k,
    input wire logic watchdog_disable,
    // Wake sources and ticks
    input wire logic [mode_ctrl_pkg::P0_PINS-1:0] port0_in,
    input wire logic [mode_ctrl_pkg::P1_PINS-1:0] port1_in,
    input wire logic timer_zero_overflow,
    input wire logic external_high_clock_tick,
    // Controls
    input wire logic high_osc_run,
    input wire logic low_rc_run,
    input wire logic sys_clock_low,
    input wire logic watchdog_clock_on,
    input wire logic cpu_run,
    input wire logic cpu_cycle,
    input wire logic timer_zero_run
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    logic slept_q;
    logic [12:0] ticks_q;

    // Ticks over a sleep; green with oscillator stop set, 32K option and watchdog off also sets slept_q
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            slept_q <= 1'b0;
            ticks_q <= 13'h0000;
        end else if (cpu_run) begin
            slept_q <= 1'b0;
            ticks_q <= 13'h0000;
        end else begin
            slept_q <= slept_q || (!high_osc_run && !low_rc_run);
            ticks_q <= ticks_q + 13'(slept_q && external_high_clock_tick);
        end
    end

    // Mode write and the halted picture it leads to
    sequence s_sleep_req;
        wr && addr == mode_ctrl_pkg::ADDR_MODE && cpu_run
            && wdata[4:3] == 2'h1;
    endsequence
    sequence s_asleep;
        !cpu_run && !high_osc_run && !low_rc_run && !timer_zero_run;
    endsequence
    property p_sleep_entry;
        s_sleep_req |-> ##3 s_asleep;
    endproperty
    property p_green_entry;
        wr && addr == mode_ctrl_pkg::ADDR_MODE && cpu_run && wdata[4:3] == 2'h2
            |-> ##3 !cpu_run
            && low_rc_run != (opt_high_32k && watchdog_disable);
    endproperty
    property p_halt_quiet;
        !cpu_run ##1 !cpu_run |-> !cpu_cycle;
    endproperty
    property p_rd_idle;
        !rd || addr == mode_ctrl_pkg::ADDR_WAKE_EN |=> rdata == 8'h00;
    endproperty
    property p_low_off;
        !low_rc_run |-> !cpu_run;
    endproperty
    property p_wdog;
        watchdog_clock_on == low_rc_run;
    endproperty
    property p_settle;
        $rose(cpu_run) && slept_q
            |-> ticks_q >= 13'h0800 && ticks_q <= 13'h0801 && !sys_clock_low;
    endproperty
    property p_green_ovf;
        timer_zero_overflow && timer_zero_run && !cpu_run |-> ##2 cpu_run;
    endproperty
    property p_no_ovf;
        s_asleep and (timer_zero_overflow && $stable(port0_in)
            && $stable(port1_in)) |=> !high_osc_run;
    endproperty
    property p_green_resume;
        $rose(cpu_run) && !slept_q |-> $stable(sys_clock_low);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("no sleep");
    a_green_entry: assert property (p_green_entry)
        else $error("no green");
    a_halt_quiet: assert property (p_halt_quiet)
        else $error("halt cycle");
    a_rd_idle: assert property (p_rd_idle)
        else $error("rdata not 0");
    a_low_off: assert property (p_low_off)
        else $error("low rc off");
    a_wdog: assert property (p_wdog)
        else $error("watchdog clock");
    a_settle: assert property (p_settle)
        else $error("settle length");
    a_green_ovf: assert property (p_green_ovf)
        else $error("ovf wake");
    a_no_ovf: assert property (p_no_ovf)
        else $error("ovf in sleep");
    a_green_resume: assert property (p_green_resume)
        else $error("mode lost");
endmodule : mode_ctrl_props

bind operating_mode_and_wakeup_control mode_ctrl_props u_props (.*);

// ### tb/osc_tick_model.sv
// Tick source standing in for the crystal and the low RC oscillator
`timescale 1ns/100ps
module osc_tick_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Oscillator enables from the block
    input wire logic high_osc_run,
    input wire logic low_rc_run,
    // Tick pulses
    output logic high_tick,
    output logic low_tick
);
    logic [1:0] phase_q;

    // Free phase count; a stopped oscillator gives no ticks at all
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) phase_q <= 2'h0;
        else phase_q <= phase_q + 2'h1;
    end

    // High clock every second cycle, low RC every fourth
    assign high_tick = high_osc_run && phase_q[0];
    assign low_tick = low_rc_run && phase_q == 2'h3;
endmodule : osc_tick_model

// ### tb/testbench.sv
// Self-checking bench for the operating mode and wakeup controller
`timescale 1ns/100ps
module testbench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic opt = 1'b0;
    logic ovf = 1'b0;
    logic [7:0] p0 = 8'h00;
    logic [5:0] p1 = 6'h00;
    logic [7:0] rdata;
    logic hosc, lrc, slow, run, cyc, t0run, htick, ltick;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [5:0] en;
    int n_errors = 0;
    int checks_done = 0;
    int n;

    always #12.5 clock = ~clock;

    osc_tick_model u_osc (.clock(clock), .rstn(rstn), .high_osc_run(hosc),
        .low_rc_run(lrc), .high_tick(htick), .low_tick(ltick));
    operating_mode_and_wakeup_control dut (.clock(clock), .rstn(rstn),
        .enable(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .opt_high_32k(opt), .watchdog_disable(opt),
        .external_high_clock_tick(htick), .internal_low_rc_tick(ltick),
        .port0_in(p0), .port1_in(p1), .timer_zero_overflow(ovf),
        .high_osc_run(hosc), .low_rc_run(lrc), .sys_clock_low(slow),
        .watchdog_clock_on(), .cpu_run(run), .cpu_cycle(cyc),
        .timer_zero_run(t0run));

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            n_errors++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // Bus cycles leave a free edge so a strobe is never set twice at once
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] want);
        exp_q.push_back(want);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(posedge clock);
    endtask : rd_reg

    task automatic count(input int len, output int nc);
        nc = 0;
        repeat (len) begin
            @(posedge clock);
            if (cyc === 1'b1) nc++;
        end
    endtask : count

    task automatic wait_run(input int lim, output int k);
        k = 0;
        while (run !== 1'b1) begin
            @(posedge clock);
            k++;
            if (k > lim) begin
                n_errors++;
                $display("[ERR] %0t wake never came", $time);
                close_out();
            end
        end
    endtask : wait_run

    // Green entry, then an overflow; a pin wakes it if the timer is off
    task automatic green(input logic [7:0] m, input logic o32);
        int k;
        opt <= o32;
        wr_reg(mode_ctrl_pkg::ADDR_MODE, m | 8'h10);
        repeat (2) @(posedge clock);
        check(8'({run, lrc, t0run}), 8'({1'b0, !o32, m[5]}));
        ovf <= 1'b1;
        @(posedge clock);
        ovf <= 1'b0;
        repeat (3) @(posedge clock);
        check(8'(run), 8'(m[5]));
        p0 <= ~p0;
        wait_run(4, k);
        check(8'(slow), 8'(m[2]));
        rd_reg(mode_ctrl_pkg::ADDR_MODE, m);
        opt <= 1'b0;
    endtask : green

    // Each read result is held against the oldest note
    always @(posedge clock) begin
        if (rd_seen && exp_q.size() > 0) begin
            check(rdata, exp_q.pop_front());
        end
        rd_seen <= rd;
    end

    initial begin
        void'($urandom(32'h12A7));
        p0 <= 8'($urandom);
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        check(8'({hosc, slow, t0run}), 8'h04);
        rd_reg(mode_ctrl_pkg::ADDR_STATUS, 8'h1C);
        rd_reg(mode_ctrl_pkg::ADDR_MODE, 8'h00);
        rd_reg(8'h55, 8'h00);
        en = (6'($urandom) | 6'h01) & 6'h3D;
        wr_reg(mode_ctrl_pkg::ADDR_WAKE_EN, {2'h0, en});
        rd_reg(mode_ctrl_pkg::ADDR_WAKE_EN, 8'h00);
        $display("test registers done");
        count(128, n);
        check(8'(n), 8'h40);
        wr_reg(mode_ctrl_pkg::ADDR_MODE, 8'h04);
        repeat (16) @(posedge clock);
        check(8'(slow), 8'h01);
        count(256, n);
        check(8'(n), 8'h10);
        wr_reg(mode_ctrl_pkg::ADDR_MODE, 8'h06);
        repeat (4) @(posedge clock);
        check(8'({hosc, run}), 8'h01);
        wr_reg(mode_ctrl_pkg::ADDR_MODE, 8'h04);
        repeat (64) @(posedge clock);
        wr_reg(mode_ctrl_pkg::ADDR_MODE, 8'h00);
        $display("test clock modes done");
        green(8'h20, 1'b0);
        green(8'h00, 1'b1);
        green(8'h24, 1'b0);
        wr_reg(mode_ctrl_pkg::ADDR_MODE, 8'h18);
        repeat (4) @(posedge clock);
        check(8'(run), 8'h01);
        wr_reg(mode_ctrl_pkg::ADDR_MODE, 8'h00);
        $display("test green done");
        wr_reg(mode_ctrl_pkg::ADDR_MODE, 8'h26);
        wr_reg(mode_ctrl_pkg::ADDR_MODE, 8'h2E);
        repeat (4) @(posedge clock);
        ovf <= 1'b1;
        @(posedge clock);
        ovf <= 1'b0;
        p1 <= p1 ^ 6'h02;
        repeat (8) @(posedge clock);
        check(8'({run, hosc, lrc, t0run}), 8'h00);
        p1 <= p1 ^ 6'h01;
        wait_run(5000, n);
        check(8'(n > 4090 && n < 4104), 8'h01);
        check(8'(slow), 8'h00);
        rd_reg(mode_ctrl_pkg::ADDR_MODE, 8'h20);
        $display("test sleep done");
        close_out();
    end
endmodule : testbench
